// ===== src/seg_flags_pkg.sv
// Contract
// - six 16-bit segment selector registers
// - fetches always use code selector
// - push-type writes always use stack selector
// - pop-type reads always use stack selector
// - string destination always uses extra selector
// - other data defaults data (stack if bp/sp base), prefix overrides
// - offset advances by length unless loaded
// - low flag half is legacy flags word
// - feature toggle writable only when enabled
// - alignment fault needs flag and mask bit
// - legacy mode faults privileged opcodes, exception 13
// - legacy mode set only by return/task switch
// - resume flag suppresses next debug fault
// - nested task flag records task nesting
// - I/O free outside protected mode, else only when privilege within field
// - popped interrupt enable obeys I/O privilege
// - overflow is carry-in xor carry-out of sign
// - direction flag picks index increment or decrement
// - interrupt enable lets maskable requests through
// - single-step trap after next instruction, clears
package seg_flags_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_SEL_EXTRA = 8'h00;
  localparam logic [7:0] OFS_SEL_CODE = 8'h04;
  localparam logic [7:0] OFS_SEL_STACK = 8'h08;
  localparam logic [7:0] OFS_SEL_DATA = 8'h0C;
  localparam logic [7:0] OFS_SEL_AUX1 = 8'h10;
  localparam logic [7:0] OFS_SEL_AUX2 = 8'h14;
  localparam logic [7:0] OFS_NEXT_IP = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1C;
  localparam logic [7:0] OFS_CFG_CTRL4 = 8'h20;
  localparam logic [7:0] OFS_SYSCTL = 8'h24;

  // segment selector indices
  localparam logic [2:0] SEG_EXTRA = 3'h0;
  localparam logic [2:0] SEG_CODE = 3'h1;
  localparam logic [2:0] SEG_STACK = 3'h2;
  localparam logic [2:0] SEG_DATA = 3'h3;
  localparam logic [2:0] SEG_AUX1 = 3'h4;
  localparam logic [2:0] SEG_AUX2 = 3'h5;
  localparam int NUM_SEG = 6;

  // status flag bit positions
  localparam int FL_OVF = 11;
  localparam int FL_DIR = 10;
  localparam int FL_IE = 9;
  localparam int FL_TRAP = 8;
  localparam int FL_ONE = 1;
  localparam int FL_IOPRIV_LO = 12;
  localparam int FL_NEST = 14;
  localparam int FL_RESUME = 16;
  localparam int FL_VLEGACY = 17;
  localparam int FL_ALIGN = 18;
  localparam int FL_FQ_TOGGLE = 21;
  localparam int CFG_CTRL4_FQ_EN = 7;
  localparam int SYSCTL_ALIGN_MASK = 18;

  // writable flag bits; 31:22, 20:19, 15, 5, 3 stay zero, bit 1 stays one
  localparam logic [31:0] FLAGS_WMASK = 32'h0027_7FD5;
  localparam logic [31:0] FLAGS_ONES = 32'h0000_0002;

  // reset values
  localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
  localparam logic [31:0] IP_RST = 32'h0000_FFF0;
  localparam logic [15:0] SEL_RST = 16'h0000;
  localparam logic [15:0] CODE_SEL_RST = 16'hF000;
  localparam logic [7:0] CFG_CTRL4_RST = 8'h00;
  localparam logic [31:0] SYSCTL_RST = 32'h0000_0000;

  // kind of memory reference, one-hot
  typedef enum logic [4:0] {
    REF_FETCH = 5'b00001,
    REF_PUSH = 5'b00010,
    REF_POP = 5'b00100,
    REF_STR_DST = 5'b01000,
    REF_DATA = 5'b10000
  } ref_kind_t;

  // source of a whole-flags load
  typedef enum logic [3:0] {
    FSRC_BUS = 4'b0001,
    FSRC_POP = 4'b0010,
    FSRC_IRET = 4'b0100,
    FSRC_TASK = 4'b1000
  } flag_src_t;

  // segment lookup request
  typedef struct packed {
    logic valid;
    ref_kind_t kind;
    logic ovr_valid;
    logic [2:0] ovr_seg;
    logic bp_sp_base;
  } seg_req_t;

  // segment lookup answer
  typedef struct packed {
    logic valid;
    logic [2:0] seg;
    logic [15:0] sel;
  } seg_ans_t;

  // software register port
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // core events in one cycle
  typedef struct packed {
    logic retire;
    logic [3:0] instr_len;
    logic ip_load;
    logic [31:0] ip_value;
    logic flags_load;
    flag_src_t flags_src;
    logic [31:0] flags_value;
    logic ovf_update;
    logic carry_into_sign;
    logic carry_out_msb;
    logic sel_load;
    logic [2:0] sel_index;
    logic [15:0] sel_value;
    logic prot_mode;
    logic [1:0] current_priv_level;
    logic io_req;
    logic priv_op;
    logic mem_access;
    logic misaligned;
    logic debug_hit;
    logic intr_req;
  } core_ev_t;

  // fault and status pulses
  typedef struct packed {
    logic io_ok;
    logic io_check;
    logic gp_fault;
    logic align_fault;
    logic debug_fault;
    logic step_trap;
    logic intr_ack;
  } core_out_t;

endpackage

// ===== src/seg_flags_regs.sv
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module seg_flags_regs
  import seg_flags_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  // core side
  input wire seg_req_t seg_req,
  input wire core_ev_t ev,
  output seg_ans_t seg_ans,
  output core_out_t core_out,
  // flag views
  output logic [31:0] processor_status_flags,
  output logic [15:0] legacy_flags,
  output logic [31:0] next_instr_offset,
  output logic index_decrement,
  output logic nested_task_flag
);

  typedef struct packed {
    logic [NUM_SEG-1:0][15:0] sel;
    logic [31:0] ip;
    logic [31:0] flags;
    logic [7:0] cfg_ctrl4;
    logic [31:0] sysctl;
    logic [31:0] rdata;
    seg_ans_t ans;
    core_out_t co;
  } state_t;

  state_t s_q;
  state_t s_d;

  // segment choice for one reference
  function automatic logic [2:0] pick_seg(input seg_req_t r);
    logic [2:0] seg;
    seg = SEG_DATA;
    case (r.kind)
      REF_FETCH:
      begin
        seg = SEG_CODE;
      end
      REF_PUSH:
      begin
        seg = SEG_STACK;
      end
      REF_POP:
      begin
        seg = SEG_STACK;
      end
      REF_STR_DST:
      begin
        seg = SEG_EXTRA;
      end
      REF_DATA:
      begin
        seg = r.bp_sp_base ? SEG_STACK : SEG_DATA;
        if (r.ovr_valid && r.ovr_seg < 3'(NUM_SEG))
        begin
          seg = r.ovr_seg;
        end
      end
      default:
      begin
        seg = SEG_DATA;
      end
    endcase
    return seg;
  endfunction

  // privilege check against the I/O field
  function automatic logic priv_ok(input logic [1:0] priv, input logic [31:0] fl);
    return priv <= fl[FL_IOPRIV_LO+1:FL_IOPRIV_LO];
  endfunction

  // merge a new flags word according to its source
  function automatic logic [31:0] merge_flags(
    input logic [31:0] old,
    input logic [31:0] val,
    input flag_src_t src,
    input logic [1:0] priv,
    input logic fq_en
  );
    logic [31:0] m;
    m = (val & FLAGS_WMASK) | FLAGS_ONES;
    if (!fq_en)
    begin
      m[FL_FQ_TOGGLE] = old[FL_FQ_TOGGLE];
    end
    if (!((src == FSRC_IRET && priv == 2'h0) || src == FSRC_TASK))
    begin
      m[FL_VLEGACY] = old[FL_VLEGACY] & val[FL_VLEGACY];
    end
    if ((src == FSRC_POP || src == FSRC_IRET) && !priv_ok(priv, old))
    begin
      m[FL_IE] = old[FL_IE];
    end
    return m;
  endfunction

  always_comb
  begin
    logic [2:0] pick;
    pick = 3'h0;
    s_d = s_q;
    s_d.co = '0;
    s_d.ans.valid = 1'h0;
    s_d.rdata = 32'h0000_0000;

    // software writes
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        OFS_SEL_EXTRA:
        begin
          s_d.sel[SEG_EXTRA] = reg_req.wdata[15:0];
        end

        OFS_SEL_CODE:
        begin
          s_d.sel[SEG_CODE] = reg_req.wdata[15:0];
        end

        OFS_SEL_STACK:
        begin
          s_d.sel[SEG_STACK] = reg_req.wdata[15:0];
        end

        OFS_SEL_DATA:
        begin
          s_d.sel[SEG_DATA] = reg_req.wdata[15:0];
        end

        OFS_SEL_AUX1:
        begin
          s_d.sel[SEG_AUX1] = reg_req.wdata[15:0];
        end

        OFS_SEL_AUX2:
        begin
          s_d.sel[SEG_AUX2] = reg_req.wdata[15:0];
        end

        OFS_NEXT_IP:
        begin
          s_d.ip = reg_req.wdata;
        end

        OFS_FLAGS:
        begin
          s_d.flags = merge_flags(s_q.flags, reg_req.wdata, FSRC_BUS,
            2'h0, s_q.cfg_ctrl4[CFG_CTRL4_FQ_EN]);
        end

        OFS_CFG_CTRL4:
        begin
          s_d.cfg_ctrl4 = reg_req.wdata[7:0];
        end

        OFS_SYSCTL:
        begin
          s_d.sysctl = reg_req.wdata;
        end

        default:
        begin
        end
      endcase
    end

    // software reads, data one cycle later
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        OFS_SEL_EXTRA:
        begin
          s_d.rdata = {16'h0000, s_q.sel[SEG_EXTRA]};
        end

        OFS_SEL_CODE:
        begin
          s_d.rdata = {16'h0000, s_q.sel[SEG_CODE]};
        end

        OFS_SEL_STACK:
        begin
          s_d.rdata = {16'h0000, s_q.sel[SEG_STACK]};
        end

        OFS_SEL_DATA:
        begin
          s_d.rdata = {16'h0000, s_q.sel[SEG_DATA]};
        end

        OFS_SEL_AUX1:
        begin
          s_d.rdata = {16'h0000, s_q.sel[SEG_AUX1]};
        end

        OFS_SEL_AUX2:
        begin
          s_d.rdata = {16'h0000, s_q.sel[SEG_AUX2]};
        end

        OFS_NEXT_IP:
        begin
          s_d.rdata = s_q.ip;
        end

        OFS_FLAGS:
        begin
          s_d.rdata = s_q.flags;
        end

        OFS_CFG_CTRL4:
        begin
          s_d.rdata = {24'h00_0000, s_q.cfg_ctrl4};
        end

        OFS_SYSCTL:
        begin
          s_d.rdata = s_q.sysctl;
        end

        default:
        begin
          s_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    if (ev.sel_load && ev.sel_index < 3'(NUM_SEG))
    begin
      s_d.sel[ev.sel_index] = ev.sel_value;
    end

    // segment lookup
    if (seg_req.valid)
    begin
      s_d.ans.valid = 1'b1;
      pick = pick_seg(seg_req);
      s_d.ans.seg = pick;
      s_d.ans.sel = s_d.sel[pick];
    end

    // whole-flags load from pop, return or task switch
    if (ev.flags_load)
    begin
      s_d.flags = merge_flags(s_q.flags, ev.flags_value, ev.flags_src,
        ev.current_priv_level, s_q.cfg_ctrl4[CFG_CTRL4_FQ_EN]);
    end

    if (ev.ovf_update)
    begin
      s_d.flags[FL_OVF] = ev.carry_into_sign ^ ev.carry_out_msb;
    end

    if (ev.io_req)
    begin
      s_d.co.io_ok = !ev.prot_mode || priv_ok(ev.current_priv_level, s_q.flags);
      s_d.co.io_check = !s_d.co.io_ok;
    end

    if (ev.priv_op && ev.prot_mode && s_q.flags[FL_VLEGACY])
    begin
      s_d.co.gp_fault = 1'h1;
    end

    if (ev.mem_access && ev.misaligned && s_q.flags[FL_ALIGN]
      && s_q.sysctl[SYSCTL_ALIGN_MASK])
    begin
      s_d.co.align_fault = 1'h1;
    end

    if (ev.debug_hit && !s_q.flags[FL_RESUME])
    begin
      s_d.co.debug_fault = 1'h1;
    end

    if (ev.intr_req && s_q.flags[FL_IE])
    begin
      s_d.co.intr_ack = 1'h1;
    end

    if (ev.retire)
    begin
      s_d.ip = s_q.ip + 32'(ev.instr_len);
      if (s_q.flags[FL_TRAP])
      begin
        s_d.co.step_trap = 1'b1;
        s_d.flags[FL_TRAP] = 1'b0;
      end
      if (!ev.flags_load)
      begin
        s_d.flags[FL_RESUME] = 1'b0;
      end
    end

    if (ev.ip_load)
    begin
      s_d.ip = ev.ip_value;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q.sel[SEG_EXTRA] <= SEL_RST;
      s_q.sel[SEG_CODE] <= CODE_SEL_RST;
      s_q.sel[SEG_STACK] <= SEL_RST;
      s_q.sel[SEG_DATA] <= SEL_RST;
      s_q.sel[SEG_AUX1] <= SEL_RST;
      s_q.sel[SEG_AUX2] <= SEL_RST;
      s_q.ip <= IP_RST;
      s_q.flags <= FLAGS_RST;
      s_q.cfg_ctrl4 <= CFG_CTRL4_RST;
      s_q.sysctl <= SYSCTL_RST;
      s_q.rdata <= 32'h0000_0000;
      s_q.ans <= '0;
      s_q.co <= '0;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign seg_ans = s_q.ans;
  assign core_out = s_q.co;
  assign processor_status_flags = s_q.flags;
  assign legacy_flags = s_q.flags[15:0];
  assign next_instr_offset = s_q.ip;
  assign index_decrement = s_q.flags[FL_DIR];
  assign nested_task_flag = s_q.flags[FL_NEST];

endmodule

// ===== testbench/seg_flags_checker.sv
`timescale 1ns/1ps
module seg_flags_checker
  import seg_flags_pkg::*;
(
  // watched ports
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire reg_req_t reg_req,
  input wire seg_req_t seg_req,
  input wire core_ev_t ev,
  input wire seg_ans_t seg_ans,
  input wire core_out_t core_out,
  input wire logic [31:0] processor_status_flags,
  input wire logic [15:0] legacy_flags,
  input wire logic [31:0] next_instr_offset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] fl;
  logic go;
  assign fl = processor_status_flags;
  assign go = ce && seg_req.valid;
  a_legacy_low_half: assert property (legacy_flags == fl[15:0])
    else $error("legacy view differs");
  a_reserved_zero: assert property ((fl & 32'hFFD8_8000) == 32'h0)
    else $error("reserved flag set");
  a_fetch_uses_code: assert property (go && seg_req.kind == REF_FETCH
    |=> seg_ans.valid && seg_ans.seg == SEG_CODE) else $error("fetch segment wrong");
  a_stack_ops_stack: assert property (go && seg_req.kind inside {REF_PUSH, REF_POP}
    |=> seg_ans.valid && seg_ans.seg == SEG_STACK) else $error("stack segment wrong");
  a_string_dst_extra: assert property (go && seg_req.kind == REF_STR_DST
    |=> seg_ans.seg == SEG_EXTRA) else $error("string segment wrong");
  a_offset_advance: assert property (ce && ev.retire && !ev.ip_load && !reg_req.wr
    |=> next_instr_offset == $past(next_instr_offset) + 32'($past(ev.instr_len)))
    else $error("offset did not advance");
  a_legacy_mode_set: assert property ($rose(fl[17]) |-> $past(ev.flags_load) &&
    ($past(ev.flags_src) == FSRC_TASK || ($past(ev.flags_src) == FSRC_IRET &&
    $past(ev.current_priv_level) == 2'h0))) else $error("legacy mode set wrongly");
  a_overflow_xor: assert property (ce && ev.ovf_update && !ev.flags_load
    |=> fl[11] == ($past(ev.carry_into_sign) ^ $past(ev.carry_out_msb)))
    else $error("overflow wrong");
  a_io_priv_check: assert property (ce && ev.io_req |=> core_out.io_ok ==
    (!$past(ev.prot_mode) || $past(ev.current_priv_level) <= $past(fl[13:12])))
    else $error("io permission wrong");
  a_step_trap_fire: assert property (ce && ev.retire && fl[8] && !ev.flags_load
    && !reg_req.wr |=> core_out.step_trap && !fl[8]) else $error("step trap wrong");
  a_legacy_priv_fault: assert property (ce |=> core_out.gp_fault ==
    ($past(ev.priv_op) && $past(ev.prot_mode) && $past(fl[17])))
    else $error("privileged fault wrong");
endmodule
bind seg_flags_regs seg_flags_checker chk_u (.clk(clk), .rst(rst), .ce(ce),
  .reg_req(reg_req), .seg_req(seg_req), .ev(ev), .seg_ans(seg_ans), .core_out(core_out),
  .processor_status_flags(processor_status_flags), .legacy_flags(legacy_flags),
  .next_instr_offset(next_instr_offset));

// ===== testbench/segment_select_and_status_flags_tb.sv
`timescale 1ns/1ps
module segment_select_and_status_flags_tb;
  import seg_flags_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  reg_req_t rq = '0;
  seg_req_t sq = '0;
  core_ev_t ev = '0;
  logic [31:0] rdata, flags, nip;
  seg_ans_t sa;
  core_out_t co;
  logic [15:0] lf;
  logic dec, nt;
  int bad_count = 0;
  int n_checks = 0;
  always #25 clk = ~clk;
  seg_flags_regs dut_u (.clk(clk), .rst(rst), .ce(ce), .reg_req(rq), .reg_rdata(rdata),
    .seg_req(sq), .ev(ev), .seg_ans(sa), .core_out(co), .processor_status_flags(flags),
    .legacy_flags(lf), .next_instr_offset(nip), .index_decrement(dec), .nested_task_flag(nt));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rq <= '{a, d, 1'h1, 1'h0};
    @(posedge clk);
    rq <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rq <= '{a, 32'h0, 1'h0, 1'h1};
    @(posedge clk);
    rq <= '0;
    #1 chk(rdata, exp);
  endtask
  task automatic pulse(input core_ev_t e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= '0;
    #1;
  endtask
  task automatic look(input ref_kind_t k, input logic ov, input logic [2:0] os,
    input logic bp, input logic [2:0] es);
    @(posedge clk);
    sq <= '{1'h1, k, ov, os, bp};
    @(posedge clk);
    sq <= '0;
    #1 chk(32'({sa.valid, sa.seg}), 32'({1'h1, es}));
  endtask
  task automatic fload(input flag_src_t s, input logic [1:0] priv, input logic [31:0] v);
    core_ev_t e;
    e = '0;
    e.flags_load = 1'h1;
    e.flags_src = s;
    e.current_priv_level = priv;
    e.flags_value = v;
    e.prot_mode = 1'h1;
    pulse(e);
  endtask
  task automatic t_regs;
    core_ev_t e;
    rd(OFS_FLAGS, FLAGS_RST);
    rd(8'h30, 32'h0);
    wr(OFS_SEL_DATA, 32'h0000_1234);
    look(REF_DATA, 1'h0, 3'h0, 1'h0, SEG_DATA);
    chk(32'(sa.sel), 32'h0000_1234);
    look(REF_FETCH, 1'h1, SEG_DATA, 1'h0, SEG_CODE);
    look(REF_PUSH, 1'h1, SEG_AUX1, 1'h0, SEG_STACK);
    look(REF_POP, 1'h1, SEG_CODE, 1'h0, SEG_STACK);
    look(REF_STR_DST, 1'h1, SEG_AUX2, 1'h1, SEG_EXTRA);
    look(REF_DATA, 1'h1, SEG_AUX2, 1'h0, SEG_AUX2);
    look(REF_DATA, 1'h0, 3'h0, 1'h1, SEG_STACK);
    look(REF_DATA, 1'h1, SEG_AUX1, 1'h1, SEG_AUX1);
    e = '0;
    e.sel_load = 1'h1;
    e.sel_index = SEG_STACK;
    e.sel_value = 16'hBEEF;
    pulse(e);
    look(REF_PUSH, 1'h0, 3'h0, 1'h0, SEG_STACK);
    chk(32'(sa.sel), 32'h0000_BEEF);
    rd(OFS_SEL_STACK, 32'h0000_BEEF);
  endtask
  task automatic t_flags;
    wr(OFS_FLAGS, 32'hFFFF_FFFF);
    rd(OFS_FLAGS, 32'h0005_7FD7);
    chk(32'({nt, dec}), 32'h3);
    chk(32'(lf), 32'h0000_7FD7);
    wr(OFS_CFG_CTRL4, 32'h0000_0080);
    wr(OFS_FLAGS, 32'h0020_0000);
    chk(flags, 32'h0020_0002);
    wr(OFS_CFG_CTRL4, 32'h0);
    wr(OFS_FLAGS, 32'h0);
    chk(flags, 32'h0020_0002);
    wr(OFS_CFG_CTRL4, 32'h0000_0080);
    wr(OFS_FLAGS, 32'h0);
    chk(flags, FLAGS_RST);
  endtask
  task automatic t_load;
    core_ev_t e;
    e = '0;
    e.priv_op = 1'h1;
    e.prot_mode = 1'h1;
    fload(FSRC_POP, 2'h0, 32'h0002_0200);
    chk(flags, 32'h0000_0202);
    fload(FSRC_IRET, 2'h1, 32'h0002_0000);
    chk(flags, 32'h0000_0202);
    fload(FSRC_IRET, 2'h0, 32'h0002_0000);
    chk(flags, 32'h0002_0002);
    fload(FSRC_TASK, 2'h3, 32'h0002_1200);
    chk(flags, 32'h0002_1202);
    pulse(e);
    chk(32'(co.gp_fault), 32'h1);
    fload(FSRC_POP, 2'h2, 32'h0000_1000);
    chk(flags, 32'h0000_1202);
    fload(FSRC_POP, 2'h1, 32'h0);
    chk(flags, FLAGS_RST);
    pulse(e);
    chk(32'(co.gp_fault), 32'h0);
  endtask
  task automatic t_core;
    core_ev_t e;
    wr(OFS_FLAGS, 32'h0000_2000);
    e = '0;
    e.io_req = 1'h1;
    e.prot_mode = 1'h1;
    e.current_priv_level = 2'h3;
    pulse(e);
    chk(32'({co.io_ok, co.io_check}), 32'h1);
    e.current_priv_level = 2'h2;
    pulse(e);
    chk(32'({co.io_ok, co.io_check}), 32'h2);
    for (int i = 0; i < 4; i++)
    begin
      e = '0;
      e.ovf_update = 1'h1;
      e.carry_into_sign = i[1];
      e.carry_out_msb = i[0];
      pulse(e);
      chk(32'(flags[11]), 32'(i[1] ^ i[0]));
    end
    wr(OFS_SYSCTL, 32'h0004_0000);
    wr(OFS_FLAGS, 32'h0005_0200);
    e = '0;
    e.mem_access = 1'h1;
    e.misaligned = 1'h1;
    e.debug_hit = 1'h1;
    e.intr_req = 1'h1;
    pulse(e);
    chk(32'({co.align_fault, co.debug_fault, co.intr_ack}), 32'h5);
    wr(OFS_FLAGS, 32'h0);
    pulse(e);
    chk(32'({co.align_fault, co.debug_fault, co.intr_ack}), 32'h2);
  endtask
  task automatic t_ip;
    core_ev_t e;
    e = '0;
    e.retire = 1'h1;
    e.instr_len = 4'hF;
    pulse(e);
    chk(nip, IP_RST + 32'h0000_000F);
    e.ip_load = 1'h1;
    e.ip_value = 32'h0000_1000;
    pulse(e);
    chk(nip, 32'h0000_1000);
    wr(OFS_FLAGS, 32'h0000_0100);
    e.ip_load = 1'h0;
    e.instr_len = 4'h3;
    pulse(e);
    chk(32'({co.step_trap, flags[8]}), 32'h2);
    chk(nip, 32'h0000_1003);
  endtask
  task automatic t_hold;
    core_ev_t e;
    e = '0;
    e.retire = 1'h1;
    e.instr_len = 4'h2;
    @(posedge clk);
    ce <= 1'h0;
    pulse(e);
    chk(nip, 32'h0000_1003);
    @(posedge clk);
    ce <= 1'h1;
    pulse(e);
    chk(nip, 32'h0000_1005);
  endtask
  task automatic t_reset;
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    #1 chk(flags, FLAGS_RST);
    chk(nip, IP_RST);
    @(posedge clk);
    rst <= 1'h0;
    rd(OFS_SEL_CODE, 32'(CODE_SEL_RST));
    rd(OFS_SEL_STACK, 32'(SEL_RST));
  endtask
  task automatic test_done;
    $display("checks=%0d bad=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    t_regs;
    t_flags;
    t_load;
    t_core;
    t_ip;
    t_hold;
    t_reset;
    test_done;
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    bad_count++;
    test_done;
  end
endmodule
